// File: hdl/regfile_defines.svh
// Offsets, reset values and field positions for the core register file
// Assumes inclusion by bare name from hdl/ sources
`ifndef REGFILE_DEFINES_SVH
`define REGFILE_DEFINES_SVH

`define RF_NUM_REGS        32
`define RF_PTR_A_LO        5'h1a
`define RF_PTR_B_LO        5'h1c
`define RF_PTR_C_LO        5'h1e
`define RF_DATA_LAST       16'h001f
`define SP_LOW_IO          6'h3d
`define SP_HIGH_IO         6'h3e
`define IO_DATA_OFFSET     16'h0020
`define SP_LOW_DATA        16'h005d
`define SP_HIGH_DATA       16'h005e
`define SP_WIDTH           11
`define SP_HIGH_BITS       3
`define SP_RESET           11'h4ff

`endif

// File: hdl/regfile_pkg.sv
// Types shared by the register file and stack pointer modules
// Assumes the defines header is compiled alongside
package regfile_pkg;
    typedef enum logic [2:0] {
        STK_NONE,
        STK_PUSH_BYTE,
        STK_PUSH_ADDR,
        STK_POP_BYTE,
        STK_POP_ADDR
    } stack_op_t;

    typedef enum logic [1:0] {
        PTR_PLAIN,
        PTR_DISP,
        PTR_POST_INC,
        PTR_PRE_DEC
    } ptr_mode_t;

    typedef enum logic [1:0] {
        PTR_SEL_A,
        PTR_SEL_B,
        PTR_SEL_C
    } ptr_sel_t;
endpackage

// File: hdl/ptr_address_unit.sv
// Effective address and write-back value for indirect pointer access
// Assumes the pointer value is read from the register file combinationally
`timescale 1ns/1ps
`include "regfile_defines.svh"

module ptr_address_unit (
    // Pointer in
    input  wire logic [15:0]           ptr_value,
    input  wire regfile_pkg::ptr_mode_t mode,
    input  wire logic [5:0]            disp,
    // Results
    output logic      [15:0]           eff_addr,
    output logic      [15:0]           ptr_next,
    output logic                       ptr_update
);
    import regfile_pkg::*;

    always_comb begin
        eff_addr   = ptr_value;
        ptr_next   = ptr_value;
        ptr_update = 1'b0;
        unique case (mode)
            PTR_PLAIN: begin
            end
            PTR_DISP: begin
                eff_addr = ptr_value + {10'h000, disp};
            end
            PTR_POST_INC: begin
                ptr_next   = ptr_value + 16'h0001;
                ptr_update = 1'b1;
            end
            PTR_PRE_DEC: begin
                eff_addr   = ptr_value - 16'h0001;
                ptr_next   = eff_addr;
                ptr_update = 1'b1;
            end
        endcase
    end
endmodule

// File: hdl/stack_pointer_unit.sv
// Stack pointer register with push and pop adjustment and byte writes
// Assumes at most one stack operation per clock from the core decode
`timescale 1ns/1ps
`include "regfile_defines.svh"

module stack_pointer_unit #(
    parameter logic [`SP_WIDTH-1:0] RESET_VALUE = `SP_RESET
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Stack operation
    input  wire regfile_pkg::stack_op_t stack_op,
    // Byte writes
    input  wire logic                  wr_low,
    input  wire logic                  wr_high,
    input  wire logic [7:0]            wr_data,
    // Value
    output logic      [`SP_WIDTH-1:0]  sp
);
    import regfile_pkg::*;

    logic [`SP_WIDTH-1:0] next_sp;

    always_comb begin
        next_sp = sp;
        unique case (stack_op)
            STK_NONE:      next_sp = sp;
            STK_PUSH_BYTE: next_sp = sp - `SP_WIDTH'(1);
            STK_PUSH_ADDR: next_sp = sp - `SP_WIDTH'(2);
            STK_POP_BYTE:  next_sp = sp + `SP_WIDTH'(1);
            STK_POP_ADDR:  next_sp = sp + `SP_WIDTH'(2);
            default:       next_sp = sp;
        endcase
        if (wr_high) begin
            next_sp[`SP_WIDTH-1:8] = wr_data[`SP_HIGH_BITS-1:0];
        end
        if (wr_low) begin
            next_sp[7:0] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp <= RESET_VALUE;
        end else begin
            sp <= next_sp;
        end
    end
endmodule

// File: hdl/cpu_register_file.sv
// Working register file with pointer pairs, data-space view and stack pointer
// Assumes the core decode drives one instruction's controls per clock
`timescale 1ns/1ps
`include "regfile_defines.svh"

module cpu_register_file (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Byte operand reads
    input  wire logic [4:0]             rd_addr_a,
    input  wire logic [4:0]             rd_addr_b,
    output logic      [7:0]             rd_data_a,
    output logic      [7:0]             rd_data_b,
    // Word operand read, even register base
    input  wire logic [3:0]             rd_pair,
    output logic      [15:0]            rd_word,
    // Byte result write
    input  wire logic                   wr_byte_en,
    input  wire logic [4:0]             wr_byte_addr,
    input  wire logic [7:0]             wr_byte_data,
    // Word result write
    input  wire logic                   wr_word_en,
    input  wire logic [3:0]             wr_word_pair,
    input  wire logic [15:0]            wr_word_data,
    // Indirect pointer access
    input  wire logic                   ptr_en,
    input  wire regfile_pkg::ptr_sel_t  ptr_sel,
    input  wire regfile_pkg::ptr_mode_t ptr_mode,
    input  wire logic [5:0]             ptr_disp,
    output logic      [15:0]            ptr_addr,
    // Data-space access
    input  wire logic                   ds_rd,
    input  wire logic                   ds_wr,
    input  wire logic [15:0]            ds_addr,
    input  wire logic [7:0]             ds_wdata,
    output logic      [7:0]             ds_rdata,
    output logic                        ds_hit,
    // I/O-space access
    input  wire logic                   io_rd,
    input  wire logic                   io_wr,
    input  wire logic [5:0]             io_addr,
    input  wire logic [7:0]             io_wdata,
    output logic      [7:0]             io_rdata,
    output logic                        io_hit,
    // Stack
    input  wire regfile_pkg::stack_op_t stack_op,
    output logic      [`SP_WIDTH-1:0]   stack_pointer
);
    import regfile_pkg::*;

    logic [7:0]  regs [`RF_NUM_REGS];
    logic [15:0] ptr_value;
    logic [15:0] ptr_next;
    logic        ptr_update;
    logic [15:0] eff_addr;
    logic [4:0]  ptr_lo;
    logic        ds_reg_hit;
    logic        ds_sp_low;
    logic        ds_sp_high;
    logic        io_sp_low;
    logic        io_sp_high;
    logic        sp_wr_low;
    logic        sp_wr_high;
    logic [7:0]  sp_wdata;

    function automatic logic [4:0] pair_low(input logic [3:0] pair);
        pair_low = {pair, 1'b0};
    endfunction

    function automatic logic [4:0] pair_high(input logic [3:0] pair);
        pair_high = {pair, 1'b1};
    endfunction

    function automatic logic [7:0] sp_byte(input logic [`SP_WIDTH-1:0] sp,
                                           input logic               high);
        sp_byte = high ? {5'h00, sp[`SP_WIDTH-1:8]} : sp[7:0];
    endfunction

    always_comb begin
        unique case (ptr_sel)
            PTR_SEL_A: ptr_lo = `RF_PTR_A_LO;
            PTR_SEL_B: ptr_lo = `RF_PTR_B_LO;
            PTR_SEL_C: ptr_lo = `RF_PTR_C_LO;
            default:   ptr_lo = `RF_PTR_A_LO;
        endcase
    end

    assign ptr_value = {regs[ptr_lo | 5'h01], regs[ptr_lo]};

    ptr_address_unit u_ptr (
        .ptr_value  (ptr_value),
        .mode       (ptr_mode),
        .disp       (ptr_disp),
        .eff_addr   (eff_addr),
        .ptr_next   (ptr_next),
        .ptr_update (ptr_update)
    );

    assign ptr_addr = eff_addr;

    // two byte reads and one word read
    assign rd_data_a = regs[rd_addr_a];
    assign rd_data_b = regs[rd_addr_b];
    assign rd_word   = {regs[pair_high(rd_pair)], regs[pair_low(rd_pair)]};

    assign ds_reg_hit = (ds_addr <= `RF_DATA_LAST);
    // stack bytes at data and I/O addresses
    assign ds_sp_low  = (ds_addr == `SP_LOW_DATA);
    assign ds_sp_high = (ds_addr == `SP_HIGH_DATA);
    assign io_sp_low  = (io_addr == `SP_LOW_IO);
    assign io_sp_high = (io_addr == `SP_HIGH_IO);
    assign ds_hit     = ds_reg_hit | ds_sp_low | ds_sp_high;
    assign io_hit     = io_sp_low | io_sp_high;

    // indirect reads of low addresses return registers
    always_comb begin
        ds_rdata = 8'h00;
        if (ds_rd && ds_reg_hit) begin
            ds_rdata = regs[ds_addr[4:0]];
        end else if (ds_rd && (ds_sp_low || ds_sp_high)) begin
            ds_rdata = sp_byte(stack_pointer, ds_sp_high);
        end
    end

    always_comb begin
        io_rdata = 8'h00;
        if (io_rd && io_hit) begin
            io_rdata = sp_byte(stack_pointer, io_sp_high);
        end
    end

    assign sp_wr_low  = (io_wr && io_sp_low) || (ds_wr && ds_sp_low);
    assign sp_wr_high = (io_wr && io_sp_high) || (ds_wr && ds_sp_high);
    assign sp_wdata   = (io_wr && io_hit) ? io_wdata : ds_wdata;

    // interrupt entry and exit use address ops
    stack_pointer_unit u_sp (
        .clk      (clk),
        .rst_n    (rst_n),
        .stack_op (stack_op),
        .wr_low   (sp_wr_low),
        .wr_high  (sp_wr_high),
        .wr_data  (sp_wdata),
        .sp       (stack_pointer)
    );

    // result written same cycle as operands read
    // every register directly writable
    // Later writes override earlier ones: pointer update loses to ALU result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `RF_NUM_REGS; i++) begin
                regs[i] <= 8'h00;
            end
        end else begin
            // pointer pair updated on one edge
            if (ptr_en && ptr_update) begin
                regs[ptr_lo]         <= ptr_next[7:0];
                regs[ptr_lo | 5'h01] <= ptr_next[15:8];
            end
            if (ds_wr && ds_reg_hit) begin
                regs[ds_addr[4:0]] <= ds_wdata;
            end
            if (wr_byte_en) begin
                regs[wr_byte_addr] <= wr_byte_data;
            end
            if (wr_word_en) begin
                regs[pair_low(wr_word_pair)]  <= wr_word_data[7:0];
                regs[pair_high(wr_word_pair)] <= wr_word_data[15:8];
            end
        end
    end

    a_push_byte: assert property (@(posedge clk) disable iff (!rst_n)
        (stack_op == STK_PUSH_BYTE && !sp_wr_low && !sp_wr_high)
        |=> stack_pointer == $past(stack_pointer) - `SP_WIDTH'(1))
        else $error("push byte did not decrement by one");
    a_push_addr: assert property (@(posedge clk) disable iff (!rst_n)
        (stack_op == STK_PUSH_ADDR && !sp_wr_low && !sp_wr_high)
        |=> stack_pointer == $past(stack_pointer) - `SP_WIDTH'(2))
        else $error("call did not decrement by two");
    a_pop_byte: assert property (@(posedge clk) disable iff (!rst_n)
        (stack_op == STK_POP_BYTE && !sp_wr_low && !sp_wr_high)
        |=> stack_pointer == $past(stack_pointer) + `SP_WIDTH'(1))
        else $error("pop byte did not increment by one");
    a_pop_addr: assert property (@(posedge clk) disable iff (!rst_n)
        (stack_op == STK_POP_ADDR && !sp_wr_low && !sp_wr_high)
        |=> stack_pointer == $past(stack_pointer) + `SP_WIDTH'(2))
        else $error("return did not increment by two");
    a_sp_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (stack_op == STK_NONE && !sp_wr_low && !sp_wr_high) |=> $stable(stack_pointer))
        else $error("stack pointer moved without cause");
    a_byte_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_byte_en && !wr_word_en && rd_addr_a == wr_byte_addr) ##1 $stable(rd_addr_a)
        |-> rd_data_a == $past(wr_byte_data))
        else $error("byte result not stored");
    a_word_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_word_en && rd_pair == wr_word_pair) ##1 $stable(rd_pair)
        |-> rd_word == $past(wr_word_data))
        else $error("word result not stored as pair");
    // I/O read of low stack byte
    a_io_sp_read: assert property (@(posedge clk) disable iff (!rst_n)
        (io_rd && io_addr == `SP_LOW_IO) |-> io_rdata == stack_pointer[7:0] && io_hit)
        else $error("low stack byte not on I/O read");
    // high byte upper bits read zero
    a_sph_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (io_rd && io_addr == `SP_HIGH_IO) |-> io_rdata[7:3] == 5'h00)
        else $error("unimplemented high bits not zero");
    a_ds_reg_read: assert property (@(posedge clk) disable iff (!rst_n)
        (ds_rd && ds_addr <= `RF_DATA_LAST) |-> ds_rdata == regs[ds_addr[4:0]])
        else $error("data-space register read mismatch");
    a_ptr_post_inc: assert property (@(posedge clk) disable iff (!rst_n)
        (ptr_en && ptr_mode == PTR_POST_INC && !wr_byte_en && !wr_word_en && !ds_wr)
        ##1 $stable(ptr_sel) |-> ptr_value == $past(ptr_value) + 16'h0001)
        else $error("post-increment did not advance pointer");
    a_ptr_pre_dec: assert property (@(posedge clk) disable iff (!rst_n)
        (ptr_en && ptr_mode == PTR_PRE_DEC && !wr_byte_en && !wr_word_en && !ds_wr)
        ##1 $stable(ptr_sel) |-> ptr_value == $past(ptr_value) - 16'h0001)
        else $error("pre-decrement did not lower pointer");
    a_pre_dec_addr: assert property (@(posedge clk) disable iff (!rst_n)
        (ptr_mode == PTR_PRE_DEC)
        |-> ptr_addr == ptr_value - 16'h0001)
        else $error("pre-decrement address wrong");
    a_disp_addr: assert property (@(posedge clk) disable iff (!rst_n)
        (ptr_mode == PTR_DISP)
        |-> ptr_addr == ptr_value + {10'h000, ptr_disp})
        else $error("displacement address wrong");
    a_ds_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
        (!ds_hit)
        |-> ds_rdata == 8'h00)
        else $error("unmapped data read not zero");
    a_io_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
        (!io_hit)
        |-> io_rdata == 8'h00)
        else $error("unmapped I/O read not zero");
    // low stack byte in data space
    a_ds_spl_read: assert property (@(posedge clk) disable iff (!rst_n)
        (ds_rd && ds_addr == `SP_LOW_DATA)
        |-> ds_rdata == stack_pointer[7:0] && ds_hit)
        else $error("low stack byte not on data read");
    // high stack byte in data space
    a_ds_sph_read: assert property (@(posedge clk) disable iff (!rst_n)
        (ds_rd && ds_addr == `SP_HIGH_DATA)
        |-> ds_rdata == {5'h00, stack_pointer[`SP_WIDTH-1:8]} && ds_hit)
        else $error("high stack byte not on data read");
    a_io_sph_read: assert property (@(posedge clk) disable iff (!rst_n)
        (io_rd && io_addr == `SP_HIGH_IO)
        |-> io_rdata == {5'h00, stack_pointer[`SP_WIDTH-1:8]} && io_hit)
        else $error("high stack byte not on I/O read");
    a_spl_write: assert property (@(posedge clk) disable iff (!rst_n)
        sp_wr_low
        |=> stack_pointer[7:0] == $past(sp_wdata))
        else $error("low stack byte write lost");
    // high byte write keeps three bits
    a_sph_write: assert property (@(posedge clk) disable iff (!rst_n)
        sp_wr_high
        |=> stack_pointer[`SP_WIDTH-1:8] == $past(sp_wdata[`SP_HIGH_BITS-1:0]))
        else $error("high stack byte write lost");
    // word read pairs odd over even
    a_word_read: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1
        |-> rd_word == {regs[{rd_pair, 1'b1}], regs[{rd_pair, 1'b0}]})
        else $error("word read pairing wrong");
    a_ds_reg_write: assert property (@(posedge clk) disable iff (!rst_n)
        (ds_wr && ds_addr <= `RF_DATA_LAST && !wr_byte_en && !wr_word_en)
        |=> regs[$past(ds_addr[4:0])] == $past(ds_wdata))
        else $error("data write missed register");
    a_byte_reg_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_byte_en && !wr_word_en)
        |=> regs[$past(wr_byte_addr)] == $past(wr_byte_data))
        else $error("byte write missed register");
    // both pair bytes on one edge
    a_word_pair_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_word_en
        |=> {regs[{$past(wr_word_pair), 1'b1}], regs[{$past(wr_word_pair), 1'b0}]} == $past(wr_word_data))
        else $error("word write split across edges");
    // pointer at last SRAM after reset
    a_reset_sp: assert property (@(posedge clk)
        $rose(rst_n)
        |-> stack_pointer == `SP_RESET)
        else $error("stack pointer reset value wrong");

    c_push_pop: cover property (@(posedge clk) disable iff (!rst_n)
        stack_op == STK_PUSH_BYTE ##1 stack_op == STK_POP_BYTE);
    c_call_ret: cover property (@(posedge clk) disable iff (!rst_n)
        stack_op == STK_PUSH_ADDR ##[1:8] stack_op == STK_POP_ADDR);
    c_ptr_inc: cover property (@(posedge clk) disable iff (!rst_n)
        ptr_en && ptr_mode == PTR_POST_INC);
    c_sp_write: cover property (@(posedge clk) disable iff (!rst_n)
        sp_wr_high ##1 sp_wr_low);
    c_pre_dec: cover property (@(posedge clk) disable iff (!rst_n)
        ptr_en && ptr_mode == PTR_PRE_DEC);
endmodule

// File: tb/alu_partner.sv
// Behavioural ALU standing at the far side of the register file
// Assumes operands come straight from the combinational read ports
`timescale 1ns/1ps

module alu_partner (
    // Operands
    input  wire logic [7:0] op_a,
    input  wire logic [7:0] op_b,
    input  wire logic       sub,
    // Result
    output logic      [7:0] result
);
    // two operands, one result
    // No register here, so the result is written back within the same cycle
    assign result = sub ? op_a - op_b : op_a + op_b;
endmodule

// File: tb/cpu_register_file_tb.sv
// Self-checking bench for working registers, pointers and stack pointer
// Assumes the hdl sources are compiled first and the header is on the path
`timescale 1ns/1ps
`include "regfile_defines.svh"
`define CHECK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t: got %h expected %h", $time, a, b); end end

module cpu_register_file_tb;
    import regfile_pkg::*;
    typedef struct {int kind; logic [15:0] val;} exp_t;
    logic        clk, rst_n, wr_byte_en, wr_word_en, ptr_en, ds_rd, ds_wr, io_rd, io_wr;
    logic        ds_hit, io_hit, use_alu, alu_sub;
    logic [3:0]  rd_pair, wr_word_pair;
    logic [4:0]  rd_addr_a, rd_addr_b, wr_byte_addr;
    logic [5:0]  ptr_disp, io_addr;
    logic [7:0]  rd_data_a, rd_data_b, wr_byte_data, bdata, ds_wdata, ds_rdata;
    logic [7:0]  io_wdata, io_rdata, alu_res;
    logic [15:0] rd_word, wr_word_data, ptr_addr, ds_addr, ptr, eff, nxt;
    logic [10:0] stack_pointer, spm;
    logic [31:0] seed;
    logic [7:0]  mdl [32];
    ptr_sel_t    ptr_sel;
    ptr_mode_t   ptr_mode;
    stack_op_t   stack_op;
    exp_t        exp_q [$];
    exp_t        e;
    int          fail_count, n_compared, k, s, m;

    assign wr_byte_data = use_alu ? alu_res : bdata;

    alu_partner alu (.op_a(rd_data_a), .op_b(rd_data_b), .sub(alu_sub), .result(alu_res));

    cpu_register_file uut (.clk, .rst_n, .rd_addr_a, .rd_addr_b, .rd_data_a, .rd_data_b,
        .rd_pair, .rd_word, .wr_byte_en, .wr_byte_addr, .wr_byte_data, .wr_word_en,
        .wr_word_pair, .wr_word_data, .ptr_en, .ptr_sel, .ptr_mode, .ptr_disp, .ptr_addr,
        .ds_rd, .ds_wr, .ds_addr, .ds_wdata, .ds_rdata, .ds_hit, .io_rd, .io_wr, .io_addr,
        .io_wdata, .io_rdata, .io_hit, .stack_op, .stack_pointer);

    always #4 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return v[0] ? (v >> 1) ^ 32'h80200003 : v >> 1;
    endfunction

    function automatic logic [15:0] actual(input int kind);
        case (kind)
            0: return {8'h00, rd_data_a};
            1: return {8'h00, rd_data_b};
            2: return rd_word;
            3: return {5'h00, stack_pointer};
            4: return {7'h00, ds_hit, ds_rdata};
            5: return {7'h00, io_hit, io_rdata};
            default: return ptr_addr;
        endcase
    endfunction

    task automatic note(input int kind, input logic [15:0] val);
        exp_q.push_back('{kind, val});
    endtask

    // One call per cycle, so no strobe is assigned twice in a time step
    task automatic set_en(input logic bw, ww, pe, dr, dw, ir, iw, input stack_op_t so);
        @(posedge clk);
        #1;
        {wr_byte_en, wr_word_en, ptr_en, ds_rd, ds_wr, io_rd, io_wr} = {bw, ww, pe, dr, dw, ir, iw};
        stack_op = so;
    endtask

    task automatic chk_regs(input logic [4:0] a, input logic [4:0] b, input logic [3:0] p);
        set_en(0, 0, 0, 1, 0, 0, 0, STK_NONE);
        rd_addr_a = a;
        rd_addr_b = b;
        rd_pair = p;
        ds_addr = {11'h000, a};
        note(0, {8'h00, mdl[a]});
        note(1, {8'h00, mdl[b]});
        note(2, {mdl[{p, 1'b1}], mdl[{p, 1'b0}]});
        note(4, {8'h01, mdl[a]});
    endtask

    task automatic summarize();
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(negedge clk) begin
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHECK(actual(e.kind), e.val)
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end

    initial begin
        {clk, rst_n, wr_byte_en, wr_word_en, ptr_en, ds_rd, ds_wr, io_rd, io_wr} = '0;
        {use_alu, alu_sub, rd_pair, wr_word_pair, rd_addr_a, rd_addr_b, wr_byte_addr} = '0;
        {ptr_disp, io_addr, bdata, ds_wdata, io_wdata, wr_word_data, ds_addr} = '0;
        ptr_sel = PTR_SEL_A;
        ptr_mode = PTR_PLAIN;
        stack_op = STK_NONE;
        seed = 32'd82029;
        spm = 11'h4ff;
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        note(3, 16'h04ff);
        for (k = 0; k < 32; k++) begin
            seed = lfsr(seed);
            set_en(1, 0, 0, 0, 0, 0, 0, STK_NONE);
            wr_byte_addr = 5'(k);
            bdata = seed[7:0];
            mdl[k] = seed[7:0];
        end
        for (k = 0; k < 32; k++) chk_regs(5'(k), 5'(31 - k), 4'(k / 2));
        for (k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            set_en(1, 0, 0, 0, 0, 0, 0, STK_NONE);
            {use_alu, alu_sub, rd_addr_a, rd_addr_b, wr_byte_addr} = {1'b1, seed[10], seed[4:0],
                seed[9:5], seed[15:11]};
            mdl[seed[15:11]] = seed[10] ? mdl[seed[4:0]] - mdl[seed[9:5]]
                                        : mdl[seed[4:0]] + mdl[seed[9:5]];
            chk_regs(seed[15:11], seed[4:0], seed[15:12]);
        end
        for (k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            set_en(0, 1, 0, 0, 0, 0, 0, STK_NONE);
            use_alu = 0;
            wr_word_pair = 4'(k);
            wr_word_data = seed[15:0];
            {mdl[2 * k + 1], mdl[2 * k]} = seed[15:0];
            chk_regs(5'(2 * k), 5'(2 * k + 1), 4'(k));
        end
        for (s = 0; s < 3; s++) begin
            for (m = 0; m < 4; m++) begin
                seed = lfsr(seed);
                ptr = {12'h000, seed[3:0]} + 16'h0004;
                set_en(0, 1, 0, 0, 0, 0, 0, STK_NONE);
                wr_word_pair = 4'(13 + s);
                wr_word_data = ptr;
                {mdl[27 + 2 * s], mdl[26 + 2 * s]} = ptr;
                set_en(0, 0, 1, 1, 0, 0, 0, STK_NONE);
                ptr_sel = ptr_sel_t'(2'(s));
                ptr_mode = ptr_mode_t'(2'(m));
                ptr_disp = seed[9:4];
                case (ptr_mode)
                    PTR_DISP: eff = ptr + {10'h000, ptr_disp};
                    PTR_PRE_DEC: eff = ptr - 16'h0001;
                    default: eff = ptr;
                endcase
                nxt = (ptr_mode == PTR_POST_INC) ? ptr + 16'h0001
                    : (ptr_mode == PTR_PRE_DEC) ? eff : ptr;
                ds_addr = eff;
                note(6, eff);
                note(4, (eff <= 16'h001f) ? {8'h01, mdl[eff[4:0]]} : 16'h0000);
                {mdl[27 + 2 * s], mdl[26 + 2 * s]} = nxt;
                chk_regs(5'(26 + 2 * s), 5'(27 + 2 * s), 4'(13 + s));
            end
        end
        for (k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            set_en(0, 0, 0, 0, 1, 0, 0, STK_NONE);
            ds_addr = {11'h000, seed[4:0]};
            ds_wdata = seed[15:8];
            mdl[seed[4:0]] = seed[15:8];
            chk_regs(seed[4:0], seed[4:0], seed[4:1]);
        end
        set_en(0, 0, 0, 0, 0, 0, 1, STK_NONE);
        io_addr = 6'h3d;
        io_wdata = seed[7:0];
        spm[7:0] = seed[7:0];
        set_en(0, 0, 0, 0, 0, 0, 1, STK_NONE);
        io_addr = 6'h3e;
        io_wdata = 8'hff;
        spm[10:8] = 3'h7;
        set_en(0, 0, 0, 0, 0, 1, 0, STK_NONE);
        note(5, {8'h01, 5'h00, spm[10:8]});
        note(3, {5'h00, spm});
        set_en(0, 0, 0, 0, 1, 0, 0, STK_NONE);
        ds_addr = 16'h005e;
        ds_wdata = 8'h04;
        spm[10:8] = 3'h4;
        set_en(0, 0, 0, 1, 0, 0, 0, STK_NONE);
        ds_addr = 16'h005d;
        note(4, {8'h01, spm[7:0]});
        set_en(0, 0, 0, 1, 0, 1, 0, STK_NONE);
        ds_addr = 16'h0040;
        io_addr = 6'h3f;
        note(4, 16'h0000);
        note(5, 16'h0000);
        for (k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            set_en(0, 0, 0, 0, 0, 0, 0, (k < 4) ? stack_op_t'(3'(k + 1))
                                                : stack_op_t'({1'b0, seed[1:0]} + 3'd1));
            note(3, {5'h00, spm});
            case (stack_op)
                STK_PUSH_BYTE: spm = spm - 11'd1;
                STK_PUSH_ADDR: spm = spm - 11'd2;
                STK_POP_BYTE: spm = spm + 11'd1;
                STK_POP_ADDR: spm = spm + 11'd2;
                default: spm = spm;
            endcase
        end
        set_en(0, 0, 0, 0, 0, 0, 0, STK_NONE);
        note(3, {5'h00, spm});
        for (k = 0; k < 4 && exp_q.size() > 0; k++) @(negedge clk);
        if (exp_q.size() > 0) fail_count++;
        summarize();
    end
endmodule
